// ===== verilog/hpf_consts.vh
`ifndef HPF_CONSTS_VH
`define HPF_CONSTS_VH

// ----------------------------------------
// Register offsets, controller side
// ----------------------------------------
`define HPF_OFF_POP_DATA 12'h100
`define HPF_OFF_CONFIG 12'h104
`define HPF_OFF_STATUS 12'h108
`define HPF_OFF_COUNT 12'h10c
`define HPF_OFF_BLOCK_ENABLE 12'h330

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HPF_EN_BIT 0
`define HPF_CFG_FLUSH_BIT 1
`define HPF_CFG_TSCLR_BIT 2
`define HPF_CFG_TB_LSB 3
`define HPF_CFG_TB_MSB 4
`define HPF_CFG_TEN_BIT 5
`define HPF_CFG_THR_LSB 6
`define HPF_CFG_THR_MSB 7
`define HPF_ST_NOT_EMPTY_BIT 0
`define HPF_ST_OVERRUN_BIT 1
`define HPF_TIME_LSB 8
`define HPF_TIME_MSB 31
`define HPF_CODE_MSB 7

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define HPF_CFG_RESET 5'h00
`define HPF_TIME_W 24
`define HPF_TIME_ZERO 24'h000000
`define HPF_TIME_ONE 24'h000001
`define HPF_THR_0 5'h01
`define HPF_THR_1 5'h04
`define HPF_THR_2 5'h08
`define HPF_THR_3 5'h0e
`define HPF_DIV_0 6'h07
`define HPF_DIV_1 6'h0f
`define HPF_DIV_2 6'h1f
`define HPF_DIV_3 6'h3f
`define HPF_PRE_ZERO 6'h00
`define HPF_PRE_ONE 6'h01

`endif

// ===== verilog/hpf_fifo.v
`timescale 1ns/1ps
// Circular store; a push into a full store evicts the oldest entry.
module hpf_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire flush_i,
   input wire push_i,
   input wire [WIDTH-1:0] push_data_i,
   input wire pop_i,
   output wire [WIDTH-1:0] head_o,
   output wire [AW:0] level_o,
   output wire full_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] rd_ptr_reg;
   reg [AW-1:0] wr_ptr_reg;
   reg [AW:0] level_reg;
   wire empty;
   wire do_pop;
   localparam [AW:0] DEPTH_L = DEPTH;
   localparam [AW:0] ONE_L = 1;
   localparam [AW-1:0] PTR_ONE = 1;

   assign empty = (level_reg == {(AW+1){1'b0}});
   assign full_o = (level_reg == DEPTH_L);
   // Eviction on overrun is modelled as a forced pop
   assign do_pop = (pop_i & ~empty) | (push_i & full_o);
   assign head_o = mem[rd_ptr_reg];
   assign level_o = level_reg;

   always @(posedge clk_i) begin
      if (push_i && !flush_i) begin
         mem[wr_ptr_reg] <= push_data_i;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ptr_reg <= {AW{1'b0}};
         wr_ptr_reg <= {AW{1'b0}};
         level_reg <= {(AW+1){1'b0}};
      end else if (flush_i) begin
         rd_ptr_reg <= {AW{1'b0}};
         wr_ptr_reg <= {AW{1'b0}};
         level_reg <= {(AW+1){1'b0}};
      end else begin
         if (push_i) begin
            wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
         end
         if (push_i && !do_pop) begin
            level_reg <= level_reg + ONE_L;
         end else if (!push_i && do_pop) begin
            level_reg <= level_reg - ONE_L;
         end
      end
   end
endmodule

// ===== verilog/hpf_top.v
`timescale 1ns/1ps
`include "hpf_consts.vh"

// Behaviour
// R1: Entry store is 32 wide, 16 deep
// R2: 24-bit free-running timestamp counter
// R3: Host write pushes byte plus timestamp
// R4: Host read of code register returns zero
// R5: Full store drops oldest, sets overflow
// R6: Only controller pops entries
// R7: Interrupt when level reaches threshold
// R8: Interrupt always driven while enabled
// R9: Enable bit 0 at 330h, resets zero
// R10: Disabled: host writes unclaimed, store flushed
// R11: Disabled: counter held zero, tick stopped
// R12: Enable leaves configuration fields unchanged
// R13: Host reaches enable via index 30h; no host index here, only controller writes at 330h
// R14: One clock, reset clears everything
// R15: Threshold codes give 1, 4, 8, 14
// R16: Tick divides clock by 8..64, gated
// R17: Pop register: code 7:0, time 31:8
// R18: Not-empty bit tracks any stored entry
// R19: Pop read removes oldest; empty reads zero
// R20: Overflow sticky until flush/disable/reset
// R21: Counter write loads; counter wraps
module hpf_top #(
   parameter DATA_W = 32,
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter ADDR_W = 12
) (
   input wire clk_i,
   input wire rst_i,
   input wire host_wr_i,
   input wire host_rd_i,
   input wire [7:0] host_wdata_i,
   output reg host_claim_o,
   output reg [7:0] host_rdata_o,
   input wire ec_wr_i,
   input wire ec_rd_i,
   input wire [ADDR_W-1:0] ec_addr_i,
   input wire [DATA_W-1:0] ec_wdata_i,
   output reg [DATA_W-1:0] ec_rdata_o,
   output reg ec_ack_o,
   output reg fill_level_irq_o
);
   // ----------------------------------------
   // Control state
   // ----------------------------------------
   reg enable_reg;
   reg [1:0] thr_sel_reg;
   reg [1:0] tick_rate_choice_reg;
   reg timer_en_reg;
   reg overrun_reg;
   reg overrun_next;
   reg [`HPF_TIME_W-1:0] time_reg;
   reg [`HPF_TIME_W-1:0] time_next;
   reg [5:0] pre_reg;
   reg [5:0] pre_next;
   reg [5:0] div_last;
   reg [AW:0] thr_level;
   reg [DATA_W-1:0] rdata_next;

   wire sel_pop = (ec_addr_i == `HPF_OFF_POP_DATA);
   wire sel_cfg = (ec_addr_i == `HPF_OFF_CONFIG);
   wire sel_cnt = (ec_addr_i == `HPF_OFF_COUNT);
   wire sel_en = (ec_addr_i == `HPF_OFF_BLOCK_ENABLE);
   wire sel_st = (ec_addr_i == `HPF_OFF_STATUS);
   wire cfg_wr = ec_wr_i & sel_cfg;
   wire cnt_wr = ec_wr_i & sel_cnt;

   wire [DATA_W-1:0] head;
   wire [AW:0] level;
   wire full;
   wire not_empty = (level != {(AW+1){1'b0}}); // R18

   // Disable flushes continuously; host writes are ignored then
   wire push = host_wr_i & enable_reg; // R3 R10
   wire pop = ec_rd_i & sel_pop & not_empty; // R6 R19
   wire flush = ~enable_reg | (cfg_wr & ec_wdata_i[`HPF_CFG_FLUSH_BIT]); // R10
   wire [DATA_W-1:0] entry = {time_reg, host_wdata_i}; // R3 R17

   // ----------------------------------------
   // Entry store
   // ----------------------------------------
   hpf_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_store ( // R1
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(flush),
      .push_i(push),
      .push_data_i(entry),
      .pop_i(pop),
      .head_o(head),
      .level_o(level),
      .full_o(full)
   );

   // ----------------------------------------
   // Timestamp counter
   // ----------------------------------------
   always @* begin
      case (tick_rate_choice_reg) // R16
         2'b00: div_last = `HPF_DIV_0;
         2'b01: div_last = `HPF_DIV_1;
         2'b10: div_last = `HPF_DIV_2;
         default: div_last = `HPF_DIV_3;
      endcase
   end

   always @* begin
      pre_next = pre_reg;
      time_next = time_reg;
      if (!enable_reg) begin
         // Prescaler held at zero too, so the first tick is a full period away
         pre_next = `HPF_PRE_ZERO; // R11
         time_next = `HPF_TIME_ZERO; // R11
      end else if (cnt_wr) begin
         time_next = ec_wdata_i[`HPF_TIME_MSB:`HPF_TIME_LSB]; // R21
      end else if (cfg_wr && ec_wdata_i[`HPF_CFG_TSCLR_BIT]) begin
         time_next = `HPF_TIME_ZERO;
      end else if (timer_en_reg) begin
         if (pre_reg >= div_last) begin
            pre_next = `HPF_PRE_ZERO;
            time_next = time_reg + `HPF_TIME_ONE; // R2 R21
         end else begin
            pre_next = pre_reg + `HPF_PRE_ONE; // R16
         end
      end
   end

   // ----------------------------------------
   // Threshold and status
   // ----------------------------------------
   always @* begin
      case (thr_sel_reg) // R15
         2'b00: thr_level = `HPF_THR_0;
         2'b01: thr_level = `HPF_THR_1;
         2'b10: thr_level = `HPF_THR_2;
         default: thr_level = `HPF_THR_3;
      endcase
   end

   always @* begin
      // Set beats clear when an overrun meets a flush
      overrun_next = overrun_reg & ~flush; // R20
      if (push && full) begin
         overrun_next = 1'b1; // R5
      end
   end

   // ----------------------------------------
   // Read mux, controller side
   // ----------------------------------------
   always @* begin
      rdata_next = {DATA_W{1'b0}};
      if (sel_pop) begin
         if (not_empty) begin
            rdata_next = head; // R17 R19
         end
      end else if (sel_cfg) begin
         rdata_next[`HPF_CFG_THR_MSB:`HPF_CFG_THR_LSB] = thr_sel_reg;
         rdata_next[`HPF_CFG_TEN_BIT] = timer_en_reg;
         rdata_next[`HPF_CFG_TB_MSB:`HPF_CFG_TB_LSB] = tick_rate_choice_reg;
      end else if (sel_st) begin
         rdata_next[`HPF_ST_OVERRUN_BIT] = overrun_reg;
         rdata_next[`HPF_ST_NOT_EMPTY_BIT] = not_empty; // R18
      end else if (sel_cnt) begin
         rdata_next[`HPF_TIME_MSB:`HPF_TIME_LSB] = time_reg;
      end else if (sel_en) begin
         rdata_next[`HPF_EN_BIT] = enable_reg;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin // R14
         enable_reg <= 1'b0; // R9
         thr_sel_reg <= 2'b00;
         tick_rate_choice_reg <= 2'b00;
         timer_en_reg <= 1'b0;
         overrun_reg <= 1'b0;
         time_reg <= `HPF_TIME_ZERO;
         pre_reg <= `HPF_PRE_ZERO;
         ec_rdata_o <= {DATA_W{1'b0}};
         ec_ack_o <= 1'b0;
         host_claim_o <= 1'b0;
         host_rdata_o <= 8'h00;
         fill_level_irq_o <= 1'b0;
      end else begin
         if (ec_wr_i && sel_en) begin
            enable_reg <= ec_wdata_i[`HPF_EN_BIT]; // R9
         end
         // Configuration is untouched by the enable bit
         if (cfg_wr) begin // R12
            thr_sel_reg <= ec_wdata_i[`HPF_CFG_THR_MSB:`HPF_CFG_THR_LSB];
            timer_en_reg <= ec_wdata_i[`HPF_CFG_TEN_BIT];
            tick_rate_choice_reg <= ec_wdata_i[`HPF_CFG_TB_MSB:`HPF_CFG_TB_LSB];
         end
         overrun_reg <= overrun_next;
         time_reg <= time_next;
         pre_reg <= pre_next;
         ec_ack_o <= ec_rd_i | ec_wr_i;
         if (ec_rd_i) begin
            ec_rdata_o <= rdata_next;
         end
         host_claim_o <= (host_wr_i | host_rd_i) & enable_reg; // R10
         host_rdata_o <= 8'h00; // R4
         // Masking lives in the system aggregator, not here
         fill_level_irq_o <= enable_reg & (level >= thr_level); // R7 R8
      end
   end
endmodule

// ===== tb/hpf_checker.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module hpf_checker #(
   parameter DATA_W = 32,
   parameter ADDR_W = 12
) (
   input wire clk_i,
   input wire rst_i,
   input wire host_wr_i,
   input wire host_rd_i,
   input wire [7:0] host_wdata_i,
   input wire host_claim_o,
   input wire [7:0] host_rdata_o,
   input wire ec_wr_i,
   input wire ec_rd_i,
   input wire [ADDR_W-1:0] ec_addr_i,
   input wire [DATA_W-1:0] ec_wdata_i,
   input wire [DATA_W-1:0] ec_rdata_o,
   input wire ec_ack_o,
   input wire fill_level_irq_o
);
   logic en_q;
   // Enable mirrored from controller writes
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) en_q <= 1'b0;
      else if (ec_wr_i && ec_addr_i == 12'h330) en_q <= ec_wdata_i[0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_HOST_RD: assert property (host_rdata_o == 8'h00)
      else $error("host read data not zero");
   AST_CLAIM: assert property ((host_wr_i || host_rd_i) |=> host_claim_o == $past(en_q))
      else $error("claim does not follow enable");
   AST_NO_CLAIM: assert property (!(host_wr_i || host_rd_i) |=> !host_claim_o)
      else $error("claim without host access");
   AST_ACK: assert property ((ec_wr_i || ec_rd_i) |=> ec_ack_o)
      else $error("controller access not acked");
   AST_RD_HOLD: assert property (!ec_rd_i |=> $stable(ec_rdata_o))
      else $error("read data moved without read");
   AST_IRQ_OFF: assert property (!en_q |=> !fill_level_irq_o)
      else $error("interrupt while disabled");
   AST_EN_RD: assert property (ec_rd_i && ec_addr_i == 12'h330 |=> ec_rdata_o[0] == $past(en_q))
      else $error("enable readback wrong");
   AST_OFF_POP: assert property ((!en_q) [*3] ##0 (ec_rd_i && ec_addr_i == 12'h100) |=> ec_rdata_o == 0)
      else $error("entry read while disabled");
   AST_OFF_CNT: assert property ((!en_q) [*3] ##0 (ec_rd_i && ec_addr_i == 12'h10c) |=> ec_rdata_o[31:8] == 0)
      else $error("counter not zero while disabled");
   cover property (host_wr_i && en_q);
   cover property ($rose(fill_level_irq_o));
   cover property (ec_rd_i && ec_addr_i == 12'h100 && en_q);
endmodule

// ===== tb/hpf_host_model.sv
`timescale 1ns/1ps
// ----
// Host side, one access per call
// ----
module hpf_host_model (
   input wire clk_i,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0,
   output logic [7:0] data_o = 8'h00
);
   task automatic put(input logic [7:0] b, input bit rd);
      @(negedge clk_i);
      wr_o = !rd;
      rd_o = rd;
      data_o = b;
      @(negedge clk_i);
      wr_o = 1'b0;
      rd_o = 1'b0;
      // Released bus shows garbage, not the old byte
      data_o = ~b;
   endtask
endmodule

// ===== tb/tb_host_postcode_fifo.sv
`timescale 1ns/1ps
module tb_host_postcode_fifo;
   logic clk_i = 0, rst_i = 1, ec_wr_i = 0, ec_rd_i = 0, ovf = 0;
   logic [11:0] ec_addr_i = 12'h000;
   logic [31:0] ec_wdata_i = 32'h0, q, v;
   wire host_wr_i, host_rd_i, host_claim_o, ec_ack_o, fill_level_irq_o;
   wire [7:0] host_wdata_i, host_rdata_o;
   wire [31:0] ec_rdata_o;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   logic [15:0] rs = 16'h23af;
   logic [31:0] mq[$];
   int thr[4] = '{1, 4, 8, 14};
   always #25 clk_i = ~clk_i;
   hpf_top u_dut(.clk_i(clk_i), .rst_i(rst_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
      .host_wdata_i(host_wdata_i), .host_claim_o(host_claim_o), .host_rdata_o(host_rdata_o),
      .ec_wr_i(ec_wr_i), .ec_rd_i(ec_rd_i), .ec_addr_i(ec_addr_i), .ec_wdata_i(ec_wdata_i),
      .ec_rdata_o(ec_rdata_o), .ec_ack_o(ec_ack_o), .fill_level_irq_o(fill_level_irq_o));
   hpf_host_model u_host(.clk_i(clk_i), .wr_o(host_wr_i), .rd_o(host_rd_i), .data_o(host_wdata_i));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic ec(input bit w, input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_i);
      ec_wr_i = w;
      ec_rd_i = !w;
      ec_addr_i = a;
      ec_wdata_i = d;
      @(negedge clk_i);
      ec_wr_i = 1'b0;
      ec_rd_i = 1'b0;
      q = ec_rdata_o;
      chk("ack", 1, ec_ack_o);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      ec(0, a, 0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // Reference store: oldest entry dropped on overrun
   task automatic push(input logic [7:0] b);
      u_host.put(b, 0);
      mq.push_back({v[31:8], b});
      if (mq.size() > 16) begin
         void'(mq.pop_front());
         ovf = 1;
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      int i;
      repeat (16) @(negedge clk_i);
      rst_i = 0;
      rd(12'h330, 0);
      rd(12'h104, 0);
      rd(12'h100, 0);
      rd(12'h10c, 0);
      u_host.put(8'h5a, 0);
      rd(12'h108, 0);
      ec(1, 12'h330, 1);
      rd(12'h330, 1);
      u_host.put(8'h00, 1);
      ec(1, 12'h104, 32'h20);
      repeat (80) @(negedge clk_i);
      ec(0, 12'h10c, 0);
      // First step 8 clocks after the config write that sets timer enable, then one per 8
      chk("tick", 10, q[31:8]);
      ec(1, 12'h104, 32'h04);
      rd(12'h10c, 0);
      rs = lfsr(rs);
      v = {rs[7:0], rs, 8'h00};
      ec(1, 12'h10c, v);
      rd(12'h10c, v);
      for (i = 0; i < 17; i++) begin
         rs = lfsr(rs);
         push(rs[7:0]);
      end
      rd(12'h108, {ovf, 1'b1});
      while (mq.size() > 0) begin
         i = mq.size() % 4;
         ec(1, 12'h104, i << 6);
         @(negedge clk_i);
         chk("irq", mq.size() >= thr[i], fill_level_irq_o);
         rd(12'h100, mq.pop_front());
      end
      rd(12'h100, 0);
      rd(12'h108, 32'h2);
      ec(1, 12'h104, 32'hc2);
      mq.delete();
      ovf = 0;
      rd(12'h108, {ovf, 1'b0});
      push(8'h3c);
      rd(12'h108, {ovf, mq.size() > 0});
      ec(1, 12'h330, 0);
      mq.delete();
      rd(12'h108, 0);
      rd(12'h104, 32'hc0);
      rd(12'h10c, 0);
      rd(12'h100, 0);
      ec(1, 12'h200, 32'hff);
      rd(12'h200, 0);
      // Slower tick rates, started from a disabled (zeroed) prescaler
      for (i = 1; i < 4; i++) begin
         ec(1, 12'h330, 0);
         ec(1, 12'h104, 32'h20 | (i << 3));
         ec(1, 12'h330, 1);
         repeat (3 * (8 << i) - 1) @(negedge clk_i);
         rd(12'h10c, 32'h300);
      end
      report_and_stop;
   end
endmodule
bind hpf_top hpf_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk(.clk_i(clk_i), .rst_i(rst_i),
   .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i), .host_claim_o(host_claim_o),
   .host_rdata_o(host_rdata_o), .ec_wr_i(ec_wr_i), .ec_rd_i(ec_rd_i), .ec_addr_i(ec_addr_i),
   .ec_wdata_i(ec_wdata_i), .ec_rdata_o(ec_rdata_o), .ec_ack_o(ec_ack_o), .fill_level_irq_o(fill_level_irq_o));
